/* cah_host_if.sv */
// Host control and tap data port of the channel correlator
`timescale 1ns/100ps
`default_nettype none
`include "cah_cfg.svh"
module cah_host_if
    import cah_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    // Control path from the host card
    input wire logic RUN_CONTROL_IN,
    input wire logic PARAM_LOAD_IN,
    input wire logic [15:0] PARAM_DATA_IN,
    // Tap data path to the host card
    input wire logic WORD_TAKEN_IN,
    output logic DATA_WAITING_OUT,
    output logic [15:0] RESULT_DATA_OUT,
    // Correlator settings
    output logic MODE_COARSE_OUT,
    output logic [3:0] AVG_SEQUENCES_OUT,
    output logic RUN_ACTIVE_OUT,
    // Correlator tap stream
    input wire logic CORR_VALID_IN,
    output logic CORR_READY_OUT,
    input wire logic [15:0] CORR_I_IN,
    input wire logic [15:0] CORR_Q_IN,
    output logic SCAN_END_OUT,
    // Gain sample port
    input wire logic SAMPLE_TAKEN_IN,
    output logic SAMPLE_WAITING_OUT,
    output logic [15:0] SAMPLE_DATA_OUT,
    output logic ADC_START_OUT,
    input wire logic ADC_DONE_IN,
    input wire logic [7:0] ADC_I_IN,
    input wire logic [7:0] ADC_Q_IN
);
    logic rst_n_meta_q;
    logic rst_n_q;
    cah_run_t run_q;
    cah_mode_t mode_q;
    logic [2:0] integ_q;
    logic [11:0] thr_q;
    logic [10:0] tap_n_q;
    logic [2:0] frame_q;
    logic eof_pend_q;
    logic [15:0] red_i_q;
    logic [15:0] red_q_q;
    logic scan_end_q;
    cah_ser_t ser_q;
    logic [47:0] triple_q;
    logic [15:0] out_word_q;
    logic out_valid_q;
    logic [1:0] out_pos_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic [4:0] fifo_level;
    logic room;
    logic corr_take;
    logic eof_take;
    logic qualify;
    logic last_tap;
    logic load_out;
    logic [11:0] mag_i;
    logic [11:0] mag_q;
    logic [13:0] idx;

    // Magnitude of the 12 bits below the sign
    function automatic logic [11:0] top_mag(input logic [15:0] v);
        logic [15:0] m;
        m = v[15] ? 16'(-v) : v;
        return m[15] ? 12'hfff : m[14:3];
    endfunction

    // Reset release through two flops
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_n_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_n_meta_q <= 1'b1;
            rst_n_q <= rst_n_meta_q;
        end
    end

    // Run state
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            run_q <= CAH_IDLE;
        end else begin
            run_q <= RUN_CONTROL_IN ? CAH_ACTIVE : CAH_IDLE;
        end
    end

    // Parameter capture
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= cah_mode_t'(`CAH_MODE_RESET);
            integ_q <= `CAH_INTEG_RESET;
            thr_q <= `CAH_THR_RESET;
        end else if (PARAM_LOAD_IN) begin
            thr_q <= PARAM_DATA_IN[`CAH_THR_HI:0];
            if (run_q == CAH_IDLE) begin
                mode_q <= cah_mode_t'(PARAM_DATA_IN[`CAH_MODE_BIT]);
                integ_q <= PARAM_DATA_IN[`CAH_INTEG_HI:`CAH_INTEG_LO];
            end
        end
    end

    assign MODE_COARSE_OUT = (mode_q == CAH_COARSE);
    assign RUN_ACTIVE_OUT = (run_q == CAH_ACTIVE);
    always_comb begin
        unique case (integ_q)
            3'h7: AVG_SEQUENCES_OUT = 4'h1;
            3'h6: AVG_SEQUENCES_OUT = 4'h2;
            3'h4: AVG_SEQUENCES_OUT = 4'h4;
            3'h0: AVG_SEQUENCES_OUT = 4'h8;
            default: AVG_SEQUENCES_OUT = 4'h1;
        endcase
    end

    // Tap sequencing and threshold test
    assign room = (fifo_level <= `CAH_FIFO_ROOM);
    assign CORR_READY_OUT = (run_q == CAH_ACTIVE) && (ser_q == CAH_SER_OFF)
        && !eof_pend_q && room;
    assign corr_take = CORR_VALID_IN && CORR_READY_OUT;
    assign eof_take = (run_q == CAH_ACTIVE) && eof_pend_q && (ser_q == CAH_SER_OFF) && room;
    assign mag_i = top_mag(CORR_I_IN);
    assign mag_q = top_mag(CORR_Q_IN);
    assign qualify = (mag_i > thr_q) || (mag_q > thr_q);
    assign last_tap = (tap_n_q == ((mode_q == CAH_COARSE) ? `CAH_COARSE_LAST : `CAH_FINE_LAST));
    // Index wraps: tap 0 of frame f is the redundant 3777f (377f coarse), then f, f+8, f+16 ...
    assign idx = {11'(tap_n_q - 11'h1), frame_q}
        & ((mode_q == CAH_COARSE) ? `CAH_COARSE_MASK : `CAH_FINE_MASK);
    assign SCAN_END_OUT = scan_end_q;

    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tap_n_q <= '0;
            frame_q <= '0;
            eof_pend_q <= 1'b0;
            scan_end_q <= 1'b0;
        end else begin
            scan_end_q <= 1'b0;
            if (run_q == CAH_IDLE) begin
                tap_n_q <= '0;
                frame_q <= '0;
                eof_pend_q <= 1'b0;
            end else if (corr_take) begin
                if (last_tap) begin
                    tap_n_q <= '0;
                    eof_pend_q <= 1'b1;
                end else begin
                    tap_n_q <= tap_n_q + 11'h1;
                end
            end else if (eof_take) begin
                eof_pend_q <= 1'b0;
                frame_q <= frame_q + 3'h1;
                scan_end_q <= (frame_q == `CAH_LAST_FRAME);
            end
        end
    end

    // Redundant tap values kept for the frame marker
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            red_i_q <= '0;
            red_q_q <= '0;
        end else if (corr_take && tap_n_q == 11'h0) begin
            red_i_q <= CORR_I_IN;
            red_q_q <= CORR_Q_IN;
        end
    end

    // Triple serializer into the queue
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ser_q <= CAH_SER_OFF;
            triple_q <= '0;
        end else begin
            unique case (ser_q)
                CAH_SER_OFF: begin
                    if (corr_take && qualify) begin
                        triple_q <= {1'b1, 1'b0, idx, CORR_I_IN, CORR_Q_IN};
                        ser_q <= CAH_SER_IDX;
                    end else if (eof_take) begin
                        triple_q <= {1'b1, 1'b1, 11'h0, frame_q, red_i_q, red_q_q};
                        ser_q <= CAH_SER_IDX;
                    end
                end
                CAH_SER_IDX: begin
                    if (fifo_in_ready) begin
                        triple_q <= {triple_q[31:0], 16'h0};
                        ser_q <= CAH_SER_I;
                    end
                end
                CAH_SER_I: begin
                    if (fifo_in_ready) begin
                        triple_q <= {triple_q[31:0], 16'h0};
                        ser_q <= CAH_SER_Q;
                    end
                end
                CAH_SER_Q: begin
                    if (fifo_in_ready) begin
                        ser_q <= CAH_SER_OFF;
                    end
                end
            endcase
        end
    end

    cah_fifo #(
        .WIDTH(`CAH_FIFO_WIDTH),
        .DEPTH(`CAH_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n_q),
        .in_valid_in(ser_q != CAH_SER_OFF),
        .in_ready_out(fifo_in_ready),
        .in_data_in(triple_q[47:32]),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(load_out),
        .out_data_out(fifo_out_data),
        .level_out(fifo_level)
    );

    // Host data register; a triple starts only once all three words wait
    assign load_out = (!out_valid_q || WORD_TAKEN_IN) && fifo_out_valid
        && (out_pos_q != 2'h0 || fifo_level >= `CAH_TRIPLE_WORDS);

    always_ff @(posedge CLK_SYS_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_word_q <= '0;
            out_valid_q <= 1'b0;
            out_pos_q <= 2'h0;
        end else if (load_out) begin
            out_word_q <= fifo_out_data;
            out_valid_q <= 1'b1;
            out_pos_q <= (out_pos_q == 2'h2) ? 2'h0 : 2'(out_pos_q + 2'h1);
        end else if (WORD_TAKEN_IN) begin
            out_valid_q <= 1'b0;
        end
    end

    assign DATA_WAITING_OUT = out_valid_q;
    assign RESULT_DATA_OUT = out_word_q;

    cah_sample_port u_sample (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n_q),
        .idle_in(run_q == CAH_IDLE),
        .taken_in(SAMPLE_TAKEN_IN),
        .waiting_out(SAMPLE_WAITING_OUT),
        .data_out(SAMPLE_DATA_OUT),
        .start_out(ADC_START_OUT),
        .done_in(ADC_DONE_IN),
        .conv_i_in(ADC_I_IN),
        .conv_q_in(ADC_Q_IN)
    );

    // Checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!rst_n_q);

    sequence s_triple;
        ser_q == CAH_SER_IDX && fifo_in_ready && triple_q[47] ##1 ser_q == CAH_SER_I;
    endsequence
    sequence s_tail;
        ser_q == CAH_SER_I && fifo_in_ready ##1 ser_q == CAH_SER_Q && fifo_in_ready
            ##1 ser_q == CAH_SER_OFF;
    endsequence

    a_run_follows_bit: assert property ($past(RUN_CONTROL_IN, 1) == RUN_ACTIVE_OUT)
        else $error("run state does not follow control bit");
    a_mode_held_active: assert property (run_q == CAH_ACTIVE |=> $stable(mode_q))
        else $error("mode changed while active");
    a_integ_held_active: assert property (run_q == CAH_ACTIVE |=> $stable(integ_q))
        else $error("averaging code changed while active");
    a_thr_capture: assert property (PARAM_LOAD_IN |=> thr_q == $past(PARAM_DATA_IN[11:0]))
        else $error("threshold not captured on load");
    a_equal_rejected: assert property (corr_take && mag_i <= thr_q && mag_q <= thr_q
        |=> ser_q == CAH_SER_OFF)
        else $error("tap at or below threshold forwarded");
    a_triple_order: assert property (ser_q == CAH_SER_IDX && fifo_in_ready |-> s_triple)
        else $error("triple words out of order");
    a_triple_tail: assert property (ser_q == CAH_SER_I |-> s_tail)
        else $error("triple tail out of order");
    a_frame_marker: assert property (corr_take && last_tap |=> eof_pend_q)
        else $error("frame marker not raised after last tap");
    a_refill_mid_triple: assert property (DATA_WAITING_OUT && WORD_TAKEN_IN
        && out_pos_q != 2'h0 |=> DATA_WAITING_OUT)
        else $error("flag dropped inside a triple");
    a_drop_after_third: assert property (DATA_WAITING_OUT && WORD_TAKEN_IN
        && out_pos_q == 2'h0 && fifo_level < `CAH_TRIPLE_WORDS |=> !DATA_WAITING_OUT)
        else $error("flag held with no triple queued");
    a_marker_word: assert property (eof_take
        |=> triple_q[47:32] == {2'b11, 11'h0, $past(frame_q)})
        else $error("frame marker word malformed");
    a_scan_last: assert property (eof_take && frame_q == `CAH_LAST_FRAME
        |=> SCAN_END_OUT)
        else $error("scan end missing after frame 7");
    a_scan_wrap: assert property (SCAN_END_OUT |-> frame_q == 3'h0)
        else $error("scan end outside frame wrap");
    a_index_first: assert property (load_out && out_pos_q == 2'h0
        |-> fifo_out_data[`CAH_VALID_BIT])
        else $error("triple does not start with index word");
    a_red_capture: assert property (corr_take && tap_n_q == 11'h0
        |=> red_i_q == $past(CORR_I_IN) && red_q_q == $past(CORR_Q_IN))
        else $error("wrapped tap values not kept for marker");
    a_mode_capture: assert property (PARAM_LOAD_IN && run_q == CAH_IDLE
        |=> MODE_COARSE_OUT == $past(PARAM_DATA_IN[`CAH_MODE_BIT]))
        else $error("mode not captured while idle");
    a_integ_capture: assert property (PARAM_LOAD_IN && run_q == CAH_IDLE
        |=> integ_q == $past(PARAM_DATA_IN[`CAH_INTEG_HI:`CAH_INTEG_LO]))
        else $error("averaging code not captured while idle");
endmodule
`default_nettype wire

/* cah_cfg.svh */
// Constants for the channel analyzer host port
`ifndef CAH_CFG_SVH
`define CAH_CFG_SVH
`define CAH_MODE_BIT 15
`define CAH_INTEG_HI 14
`define CAH_INTEG_LO 12
`define CAH_THR_HI 11
`define CAH_VALID_BIT 15
`define CAH_EOF_BIT 14
`define CAH_MODE_RESET 1'b0
`define CAH_INTEG_RESET 3'h7
`define CAH_THR_RESET 12'hfff
`define CAH_FINE_LAST 11'h7fe
`define CAH_COARSE_LAST 11'h0fe
`define CAH_FINE_MASK 14'h3fff
`define CAH_COARSE_MASK 14'h07ff
`define CAH_LAST_FRAME 3'h7
`define CAH_FIFO_WIDTH 16
`define CAH_FIFO_DEPTH 16
`define CAH_FIFO_ROOM 5'h0d
`define CAH_TRIPLE_WORDS 5'h03
`endif

/* cah_pkg.sv */
// Types shared by the channel analyzer host port
`default_nettype none
package cah_pkg;
    typedef enum logic [0:0] {CAH_IDLE = 1'b0, CAH_ACTIVE = 1'b1} cah_run_t;
    typedef enum logic [0:0] {CAH_FINE = 1'b0, CAH_COARSE = 1'b1} cah_mode_t;
    typedef enum logic [1:0] {CAH_SER_IDX = 2'b00, CAH_SER_I = 2'b01, CAH_SER_Q = 2'b10,
                              CAH_SER_OFF = 2'b11} cah_ser_t;
    typedef enum logic [1:0] {CAH_SP_IDLE = 2'b00, CAH_SP_CONV = 2'b01,
                              CAH_SP_HOLD = 2'b10} cah_sp_t;
endpackage
`default_nettype wire

/* cah_fifo.sv */
// Word FIFO between the tap serializer and the host data register
`timescale 1ns/100ps
`default_nettype none
module cah_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] level_q;
    logic push;
    logic pop;

    assign in_ready_out = (level_q != (AW+1)'(DEPTH));
    assign out_valid_out = (level_q != '0);
    assign out_data_out = mem_q[rd_ptr_q];
    assign level_out = level_q;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
                level_q <= level_q - 1'b1;
            end
        end
    end

    a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        level_q == (AW+1)'(DEPTH) |-> !in_valid_in)
        else $error("fifo offered a word while full");
endmodule
`default_nettype wire

/* cah_sample_port.sv */
// Converter sample port: trigger, hold and packed read of I/Q samples
`timescale 1ns/100ps
`default_nettype none
module cah_sample_port
    import cah_pkg::*;
(
    // Clock, reset and run-state idle flag
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic idle_in,
    // Host side
    input wire logic taken_in,
    output logic waiting_out,
    output logic [15:0] data_out,
    // Converters
    output logic start_out,
    input wire logic done_in,
    input wire logic [7:0] conv_i_in,
    input wire logic [7:0] conv_q_in
);
    cah_sp_t state_q;
    logic go;

    assign go = taken_in && idle_in;
    assign start_out = go && (state_q != CAH_SP_CONV);
    assign waiting_out = (state_q == CAH_SP_HOLD);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= CAH_SP_IDLE;
        end else begin
            unique case (state_q)
                CAH_SP_IDLE: begin
                    if (go) begin
                        state_q <= CAH_SP_CONV;
                    end
                end
                CAH_SP_CONV: begin
                    if (done_in) begin
                        state_q <= CAH_SP_HOLD;
                    end
                end
                CAH_SP_HOLD: begin
                    if (go) begin
                        state_q <= CAH_SP_CONV;
                    end
                end
                default: begin
                    state_q <= CAH_SP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= '0;
        end else if (state_q == CAH_SP_CONV && done_in) begin
            data_out <= {conv_i_in, conv_q_in};
        end
    end

    a_ignore_when_active: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        taken_in && !idle_in && state_q == CAH_SP_HOLD |=> waiting_out)
        else $error("sample pulse acted on while active");
    a_hold_after_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == CAH_SP_CONV && done_in |=> waiting_out
            && data_out == {$past(conv_i_in), $past(conv_q_in)})
        else $error("sample not held after conversion");
endmodule
`default_nettype wire

/* cah_host_model.sv */
// Host card model that drains the tap data port
`timescale 1ns/100ps
`default_nettype none
module cah_host_model (
    // Clock and pacing
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic slow_in,
    // Tap data port
    input wire logic waiting_in,
    input wire logic [15:0] data_in,
    output logic taken_out
);
    logic [15:0] got[$];
    int split_drops = 0;
    logic waiting_q;
    // Pulses word-taken per waiting word, back to back or spaced
    always @(posedge clk_in) begin
        if (taken_out && waiting_in) begin
            got.push_back(data_in);
        end
        if (waiting_q && !waiting_in && (got.size() % 3 != 0)) begin
            split_drops++;
        end
        waiting_q <= waiting_in;
        taken_out <= waiting_in && !stall_in && !(slow_in && taken_out);
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the channel analyzer host port
`timescale 1ns/100ps
`default_nettype none
`include "cah_cfg.svh"
module tb_top;
    localparam logic [11:0] THR = 12'h100;
    logic clk, rst_n, run, pload, wtaken, stall, slow, cvalid, staken, adone;
    logic waiting, cready, mode, active, scan_end, swait, astart;
    logic [15:0] pdata, ci, cq, rdata, sdata;
    logic [7:0] ai, aq;
    logic [3:0] avg;
    int bad_count = 0, check_count = 0, cyc = 0, scan_ends = 0;
    logic [15:0] exp_q[$];
    logic [15:0] tbl_i [8] = '{16'h0800, 16'h0808, 16'h0000, 16'h0807,
                               16'h8000, 16'h0000, 16'h7fff, 16'h0100};
    logic [15:0] tbl_q [8] = '{16'h0000, 16'h0000, 16'hf7f8, 16'hf800,
                               16'h0000, 16'h0000, 16'h0001, 16'hff00};
    logic [2:0] codes [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    logic [3:0] counts [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

    cah_host_if dut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .RUN_CONTROL_IN(run),
        .PARAM_LOAD_IN(pload), .PARAM_DATA_IN(pdata), .WORD_TAKEN_IN(wtaken),
        .DATA_WAITING_OUT(waiting), .RESULT_DATA_OUT(rdata), .MODE_COARSE_OUT(mode),
        .AVG_SEQUENCES_OUT(avg), .RUN_ACTIVE_OUT(active), .CORR_VALID_IN(cvalid),
        .CORR_READY_OUT(cready), .CORR_I_IN(ci), .CORR_Q_IN(cq), .SCAN_END_OUT(scan_end),
        .SAMPLE_TAKEN_IN(staken), .SAMPLE_WAITING_OUT(swait), .SAMPLE_DATA_OUT(sdata),
        .ADC_START_OUT(astart), .ADC_DONE_IN(adone), .ADC_I_IN(ai), .ADC_Q_IN(aq));
    cah_host_model host (.clk_in(clk), .stall_in(stall), .slow_in(slow),
        .waiting_in(waiting), .data_in(rdata), .taken_out(wtaken));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic summarize;
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        stall <= (cyc % 700) < 50;
        if (rst_n && scan_end === 1'b1) begin
            scan_ends++;
        end
        if (cyc == 40000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic load(input logic [15:0] w);
        @(posedge clk);
        pload <= 1'b1;
        pdata <= w;
        @(posedge clk);
        pload <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic set_run(input logic v);
        @(posedge clk);
        run <= v;
        repeat (2) @(posedge clk);
        #1;
        check("run state", {15'h0, active}, {15'h0, v});
    endtask

    task automatic sample_pulse(input logic start);
        @(posedge clk);
        staken <= 1'b1;
        #1;
        check("adc start", {15'h0, astart}, {15'h0, start});
        @(posedge clk);
        staken <= 1'b0;
        #1;
        check("sample waiting", {15'h0, swait}, {15'h0, !start});
    endtask

    task automatic convert(input logic [7:0] i, input logic [7:0] q);
        @(posedge clk);
        ai <= i;
        aq <= q;
        repeat (3) @(posedge clk);
        adone <= 1'b1;
        @(posedge clk);
        adone <= 1'b0;
        @(posedge clk);
        #1;
        check("sample waiting", {15'h0, swait}, 16'h0001);
        check("sample word", sdata, {i, q});
    endtask

    function automatic logic [11:0] mag12(input logic [15:0] v);
        logic [15:0] a;
        a = v[15] ? (~v + 16'h0001) : v;
        return (v == 16'h8000) ? 12'hfff : a[14:3];
    endfunction

    // Offers one tap and holds it until ready is seen at a falling edge, then steps to the next rising edge
    task automatic send_tap(input logic [15:0] i, input logic [15:0] q);
        logic r;
        cvalid <= 1'b1;
        ci <= i;
        cq <= q;
        do begin
            @(negedge clk);
            r = cready;
            @(posedge clk);
        end while (!r);
    endtask

    task automatic run_frame(input int f, input int taps, input logic [13:0] mask);
        int x;
        logic [13:0] ix;
        for (int n = 0; n < taps; n++) begin
            x = (n - 1) * 8 + f;
            ix = x[13:0] & mask;
            if (mag12(tbl_i[n % 8]) > THR || mag12(tbl_q[n % 8]) > THR) begin
                exp_q.push_back({2'b10, ix});
                exp_q.push_back(tbl_i[n % 8]);
                exp_q.push_back(tbl_q[n % 8]);
            end
            send_tap(tbl_i[n % 8], tbl_q[n % 8]);
        end
        exp_q.push_back({2'b11, 11'h000, f[2:0]});
        exp_q.push_back(tbl_i[0]);
        exp_q.push_back(tbl_q[0]);
    endtask

    task automatic drain_and_compare;
        int t;
        t = 0;
        cvalid <= 1'b0;
        while (host.got.size() < exp_q.size() && t < 20000) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
        #1;
        check("word count", 16'(host.got.size()), 16'(exp_q.size()));
        foreach (exp_q[k]) check("tap word", host.got[k], exp_q[k]);
        check("split triples", 16'(host.split_drops), 16'h0000);
        check("waiting after drain", {15'h0, waiting}, 16'h0000);
        exp_q.delete();
        host.got.delete();
    endtask

    initial begin
        {rst_n, run, pload, slow, cvalid, staken, adone} = '0;
        {pdata, ci, cq, ai, aq} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("mode at reset", {15'h0, mode}, 16'h0000);
        check("count at reset", {12'h0, avg}, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            load({1'b1, codes[k], THR});
            check("sequence count", {12'h0, avg}, {12'h0, counts[k]});
            check("coarse mode", {15'h0, mode}, 16'h0001);
        end
        // The first read only triggers; its value is thrown away
        check("first sample word", sdata, 16'h0000);
        sample_pulse(1'b1);
        convert(8'h81, 8'h7f);
        sample_pulse(1'b1);
        convert(8'h12, 8'hfe);
        set_run(1'b1);
        @(posedge clk);
        staken <= 1'b1;
        #1;
        check("start while active", {15'h0, astart}, 16'h0000);
        @(posedge clk);
        staken <= 1'b0;
        #1;
        check("sample held", {15'h0, swait}, 16'h0001);
        load({1'b0, 3'h6, THR});
        check("mode kept", {15'h0, mode}, 16'h0001);
        check("count kept", {12'h0, avg}, 16'h0008);
        slow <= 1'b1;
        @(posedge clk);
        for (int f = 0; f < 8; f++) run_frame(f, 255, `CAH_COARSE_MASK);
        drain_and_compare();
        check("scan ends", 16'(scan_ends), 16'h0001);
        set_run(1'b0);
        check("ready while idle", {15'h0, cready}, 16'h0000);
        load({1'b0, 3'h7, THR});
        check("fine mode", {15'h0, mode}, 16'h0000);
        set_run(1'b1);
        slow <= 1'b0;
        @(posedge clk);
        run_frame(0, 2047, `CAH_FINE_MASK);
        drain_and_compare();
        check("scan ends", 16'(scan_ends), 16'h0001);
        summarize();
    end
endmodule
`default_nettype wire
